// ---- logic/modbus_write_multiple_slave.sv ----
/*
  Slave decoder and responder for write-multiple-coils and
  write-multiple-registers requests. Takes a deframed byte stream with
  an end-of-frame pulse, checks it, writes the stores, sends the echo.
  Assumes byte stream, end pulse and transmitter run on clk_i.
*/
// Overview of operation
// - Byte one of each frame is the slave address, legal from 1 to 247.
// - Codes 0x0f and 0x3f write a run of consecutive bits.
// - The bit count is a 16-bit big-endian field of at most 1968.
// - The bit byte count is (count + 7) / 8 and that many bytes follow.
// - Each data byte holds eight bits, first bit in the lowest position.
// - Every frame ends with a two-byte check code sent high byte first.
// - A bit write is answered by address, code, start, count and check.
// - Code 0x10 writes consecutive words into the general word store.
// - Code 0x40 writes consecutive words into the system word store.
// - The word count is at most 120.
// - A word write is answered by address, code, start, count, check.
// - Each word is two bytes high first, lowest address first.
`timescale 1ns/1ps
`default_nettype none

module modbus_write_multiple_slave
  import mbw_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire logic [7:0]         slave_addr_i,
  input  wire logic [7:0]         rx_byte_i,
  input  wire logic               rx_valid_i,
  input  wire logic               rx_end_i,
  output logic      [7:0]         tx_byte_o,
  output logic                    tx_valid_o,
  input  wire logic               tx_ready_i,
  output logic                    frame_ok_o,
  output logic                    frame_drop_o,
  input  wire logic [COIL_AW-1:0] coil_rd_addr_i,
  input  wire logic [WORD_AW-1:0] word_rd_addr_i,
  input  wire logic               word_rd_sys_i,
  output logic                    coil_rd_o,
  output logic      [15:0]        word_rd_o
);

  // ****************************************************************
  // Receive side
  // ****************************************************************
  state_t      state_r, state_nxt;
  hdr_t        hdr_r, hdr_nxt;
  logic [8:0]  cnt_r, cnt_nxt;
  logic [7:0]  last_r [2];
  logic [7:0]  last_nxt[2];
  logic [7:0]  pay_r [PAY_MAX];
  logic [7:0]  pay_nxt[PAY_MAX];
  logic [15:0] rx_crc;
  logic        rx_take;

  assign rx_take = rx_valid_i && (state_r == S_RECV);

  mbw_crc u_rx_crc (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .init_i   (state_r == S_CHECK),
    .en_i     (rx_take && (cnt_r >= 9'h002)),
    .data_i   (last_r[1]),
    .crc_o    (rx_crc)
  );

  always_comb
  begin
    hdr_nxt  = hdr_r;
    cnt_nxt  = cnt_r;
    last_nxt = last_r;
    pay_nxt  = pay_r;
    if (state_r == S_CHECK)
      cnt_nxt = 9'h000;
    if (rx_take)
    begin
      last_nxt[0] = rx_byte_i;
      last_nxt[1] = last_r[0];
      if (cnt_r != CNT_SAT)
        cnt_nxt = cnt_r + 9'h001;
      case (cnt_r)
        9'h000: hdr_nxt.addr        = rx_byte_i;
        9'h001: hdr_nxt.func        = rx_byte_i;
        9'h002: hdr_nxt.start[15:8] = rx_byte_i;
        9'h003: hdr_nxt.start[7:0]  = rx_byte_i;
        9'h004: hdr_nxt.qty[15:8]   = rx_byte_i;
        9'h005: hdr_nxt.qty[7:0]    = rx_byte_i;
        9'h006: hdr_nxt.bcnt        = rx_byte_i;
        default:
        begin
          if (cnt_r - HDR_LEN < 9'(PAY_MAX))
            pay_nxt[8'(cnt_r - HDR_LEN)] = rx_byte_i;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hdr_r  <= '0;
      cnt_r  <= 9'h000;
      last_r <= '{default: 8'h00};
      pay_r  <= '{default: 8'h00};
    end
    else
    begin
      hdr_r  <= hdr_nxt;
      cnt_r  <= cnt_nxt;
      last_r <= last_nxt;
      pay_r  <= pay_nxt;
    end
  end

  // ****************************************************************
  // Frame check
  // ****************************************************************
  logic        is_coil, is_word, size_ok, frame_good;
  logic [16:0] qty_ext, end_addr, pack_len;

  assign is_coil  = (hdr_r.func == FN_COILS) ||
                    (hdr_r.func == FN_COILS_ALT);
  assign is_word  = (hdr_r.func == FN_WORDS) ||
                    (hdr_r.func == FN_WORDS_SYS);
  assign qty_ext  = {1'b0, hdr_r.qty};
  assign end_addr = {1'b0, hdr_r.start} + qty_ext;
  assign pack_len = (qty_ext + 17'h00007) >> 3;

  always_comb
  begin
    size_ok = 1'b0;
    if (is_coil)
      size_ok = (hdr_r.qty <= COIL_MAX) &&
                (pack_len == {9'h000, hdr_r.bcnt}) &&
                (end_addr <= COIL_DEPTH);
    else if (is_word)
      size_ok = (hdr_r.qty <= WORD_MAX) &&
                (qty_ext * 17'h00002 == {9'h000, hdr_r.bcnt}) &&
                (end_addr <= WORD_DEPTH);
  end

  assign frame_good = size_ok && (hdr_r.qty != 16'h0000) &&
    (cnt_r == HDR_LEN + {1'b0, hdr_r.bcnt} + CRC_LEN) &&
    (hdr_r.addr == slave_addr_i) &&
    (slave_addr_i >= ADDR_MIN) && (slave_addr_i <= ADDR_MAX) &&
    (rx_crc == {last_r[1], last_r[0]});

  // ****************************************************************
  // Control, commit and reply
  // ****************************************************************
  logic [15:0] item_r, item_nxt;
  store_wr_t   wr_r, wr_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic [7:0]  tx_byte_r, tx_byte_nxt;
  logic        tx_valid_r, tx_valid_nxt;
  logic        ok_r, ok_nxt, drop_r, drop_nxt;
  logic [15:0] tx_crc;
  logic        tx_fire;

  assign tx_fire = tx_valid_r && tx_ready_i;

  mbw_crc u_tx_crc (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .init_i   (state_r == S_CHECK),
    .en_i     (tx_fire && (idx_r < RESP_CRC_HI)),
    .data_i   (tx_byte_r),
    .crc_o    (tx_crc)
  );

  function automatic logic [7:0] reply_byte(input logic [3:0]  i,
                                            input hdr_t        h,
                                            input logic [15:0] c);
    case (i)
      4'h0:    reply_byte = h.addr;
      4'h1:    reply_byte = h.func;
      4'h2:    reply_byte = h.start[15:8];
      4'h3:    reply_byte = h.start[7:0];
      4'h4:    reply_byte = h.qty[15:8];
      4'h5:    reply_byte = h.qty[7:0];
      4'h6:    reply_byte = c[15:8];
      default: reply_byte = c[7:0];
    endcase
  endfunction : reply_byte

  always_comb
  begin
    state_nxt    = state_r;
    item_nxt     = item_r;
    wr_nxt       = '0;
    idx_nxt      = idx_r;
    tx_byte_nxt  = tx_byte_r;
    tx_valid_nxt = tx_valid_r;
    ok_nxt       = 1'b0;
    drop_nxt     = 1'b0;
    case (state_r)
      S_RECV:
      begin
        if (rx_end_i && (rx_take || cnt_r != 9'h000))
          state_nxt = S_CHECK;
      end
      S_CHECK:
      begin
        item_nxt  = 16'h0000;
        idx_nxt   = 4'h0;
        ok_nxt    = frame_good;
        drop_nxt  = !frame_good;
        state_nxt = frame_good ? S_COMMIT : S_RECV;
      end
      S_COMMIT:
      begin
        wr_nxt.addr = hdr_r.start + item_r;
        if (is_coil)
        begin
          wr_nxt.bit_we  = 1'b1;
          wr_nxt.bit_val = pay_r[item_r[10:3]][item_r[2:0]];
        end
        else
        begin
          wr_nxt.word_we = 1'b1;
          wr_nxt.sys     = (hdr_r.func == FN_WORDS_SYS);
          wr_nxt.word    = {pay_r[{item_r[6:0], 1'b0}],
                            pay_r[{item_r[6:0], 1'b1}]};
        end
        item_nxt = item_r + 16'h0001;
        if (item_nxt == hdr_r.qty)
          state_nxt = S_REPLY;
      end
      S_REPLY:
      begin
        if (tx_fire)
        begin
          tx_valid_nxt = 1'b0;
          idx_nxt      = idx_r + 4'h1;
        end
        else if (!tx_valid_r && idx_r < RESP_LEN)
        begin
          tx_valid_nxt = 1'b1;
          tx_byte_nxt  = reply_byte(idx_r, hdr_r, tx_crc);
        end
        else if (!tx_valid_r)
          state_nxt = S_RECV;
      end
      default: state_nxt = S_RECV;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r    <= S_RECV;
      item_r     <= 16'h0000;
      wr_r       <= '0;
      idx_r      <= 4'h0;
      tx_byte_r  <= 8'h00;
      tx_valid_r <= 1'b0;
      ok_r       <= 1'b0;
      drop_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      item_r     <= item_nxt;
      wr_r       <= wr_nxt;
      idx_r      <= idx_nxt;
      tx_byte_r  <= tx_byte_nxt;
      tx_valid_r <= tx_valid_nxt;
      ok_r       <= ok_nxt;
      drop_r     <= drop_nxt;
    end
  end

  mbw_store u_store (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .wr_i           (wr_r),
    .coil_rd_addr_i (coil_rd_addr_i),
    .word_rd_addr_i (word_rd_addr_i),
    .word_rd_sys_i  (word_rd_sys_i),
    .coil_rd_o      (coil_rd_o),
    .word_rd_o      (word_rd_o)
  );

  assign tx_byte_o    = tx_byte_r;
  assign tx_valid_o   = tx_valid_r;
  assign frame_ok_o   = ok_r;
  assign frame_drop_o = drop_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_foreign_drop;
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_r == S_CHECK && hdr_r.addr != slave_addr_i)
      |=> frame_drop_o ##1 (state_r == S_RECV && !wr_r.bit_we);
  endproperty
  a_foreign_drop: assert property (p_foreign_drop)
    else $error("foreign frame not dropped");

  property p_bcnt_drop;
    @(posedge clk_i) disable iff (!arst_n_i)
    (state_r == S_CHECK && is_coil && pack_len != {9'h000, hdr_r.bcnt})
      |=> (state_r == S_RECV) [*2];
  endproperty
  a_bcnt_drop: assert property (p_bcnt_drop)
    else $error("bad byte count reached commit");

  property p_bit_func;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_r.bit_we |-> (hdr_r.func == FN_COILS || hdr_r.func == FN_COILS_ALT);
  endproperty
  a_bit_func: assert property (p_bit_func)
    else $error("bit write for wrong code");

  property p_gp_store;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_r.word_we && !wr_r.sys) |-> hdr_r.func == FN_WORDS;
  endproperty
  a_gp_store: assert property (p_gp_store)
    else $error("general store written by wrong code");

  property p_sys_store;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_r.word_we && wr_r.sys) |-> hdr_r.func == FN_WORDS_SYS;
  endproperty
  a_sys_store: assert property (p_sys_store)
    else $error("system store written by wrong code");

  property p_bit_limit;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_r.bit_we |-> hdr_r.qty <= COIL_MAX;
  endproperty
  a_bit_limit: assert property (p_bit_limit)
    else $error("bit count above limit written");

  property p_word_limit;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_r.word_we |-> hdr_r.qty <= WORD_MAX;
  endproperty
  a_word_limit: assert property (p_word_limit)
    else $error("word count above limit written");

  property p_bit_order;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_r.bit_we |-> wr_r.bit_val ==
      pay_r[8'((wr_r.addr - hdr_r.start) >> 3)][3'(wr_r.addr - hdr_r.start)];
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("bit taken from wrong position");

  property p_reply_head;
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(tx_valid_r) && idx_r == 4'h0 |->
      tx_byte_r == hdr_r.addr
      ##[1:300] (tx_valid_r && tx_byte_r == hdr_r.func);
  endproperty
  a_reply_head: assert property (p_reply_head)
    else $error("reply does not open with address and code");

  property p_tx_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    (tx_valid_r && !tx_ready_i) |=> tx_valid_r && $stable(tx_byte_r);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("reply byte dropped before taken");

  property p_crc_hi;
    @(posedge clk_i) disable iff (!arst_n_i)
    (tx_valid_r && idx_r == RESP_CRC_HI) |-> tx_byte_r == tx_crc[15:8];
  endproperty
  a_crc_hi: assert property (p_crc_hi)
    else $error("check code high byte not first");

endmodule : modbus_write_multiple_slave

`default_nettype wire

// ---- logic/mbw_pkg.sv ----
/*
  Shared constants and types of the write-multiple slave: frame layout,
  function codes, limits, store sizes and the check-code polynomial.
  Assumes the byte stream is already deframed by a same-clock receiver.
*/
`default_nettype none

package mbw_pkg;

  // ****************************************************************
  // Frame layout and limits
  // ****************************************************************
  localparam logic [7:0]  FN_COILS      = 8'h0f;
  localparam logic [7:0]  FN_COILS_ALT  = 8'h3f;
  localparam logic [7:0]  FN_WORDS      = 8'h10;
  localparam logic [7:0]  FN_WORDS_SYS  = 8'h40;
  localparam logic [7:0]  ADDR_MIN      = 8'h01;
  localparam logic [7:0]  ADDR_MAX      = 8'hf7;
  localparam logic [15:0] COIL_MAX      = 16'h07b0;
  localparam logic [15:0] WORD_MAX      = 16'h0078;
  localparam logic [8:0]  HDR_LEN       = 9'h007;
  localparam logic [8:0]  CRC_LEN       = 9'h002;
  localparam logic [8:0]  CNT_SAT       = 9'h1ff;
  localparam logic [3:0]  RESP_LEN      = 4'h8;
  localparam logic [3:0]  RESP_CRC_HI   = 4'h6;
  localparam int          PAY_MAX       = 246;

  // ****************************************************************
  // Stores and check code
  // ****************************************************************
  localparam int          COIL_AW       = 11;
  localparam int          WORD_AW       = 8;
  localparam logic [16:0] COIL_DEPTH    = 17'h00800;
  localparam logic [16:0] WORD_DEPTH    = 17'h00100;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;

  typedef enum logic [1:0] {
    S_RECV   = 2'b00,
    S_CHECK  = 2'b01,
    S_COMMIT = 2'b10,
    S_REPLY  = 2'b11
  } state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] qty;
    logic [7:0]  bcnt;
  } hdr_t;

  typedef struct packed {
    logic        bit_we;
    logic        word_we;
    logic        sys;
    logic [15:0] addr;
    logic        bit_val;
    logic [15:0] word;
  } store_wr_t;

  // One byte through the check-code shift register
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
                                             input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int k = 0; k < 8; k++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte

endpackage : mbw_pkg

`default_nettype wire

// ---- logic/mbw_crc.sv ----
/*
  Check-code accumulator: one byte per enable, restart on init.
  Assumes init and enable come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module mbw_crc
  import mbw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        init_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  data_i,
  output logic      [15:0] crc_o
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  always_comb
  begin
    crc_nxt = crc_r;
    if (init_i)
      crc_nxt = CRC_INIT;
    else if (en_i)
      crc_nxt = crc16_byte(crc_r, data_i);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      crc_r <= CRC_INIT;
    else
      crc_r <= crc_nxt;
  end

  assign crc_o = crc_r;

endmodule : mbw_crc

`default_nettype wire

// ---- logic/mbw_store.sv ----
/*
  Bit store and the two word stores (general-purpose and system) with
  one write port and registered read ports for the rest of the device.
*/
`timescale 1ns/1ps
`default_nettype none

module mbw_store
  import mbw_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire store_wr_t          wr_i,
  input  wire logic [COIL_AW-1:0] coil_rd_addr_i,
  input  wire logic [WORD_AW-1:0] word_rd_addr_i,
  input  wire logic               word_rd_sys_i,
  output logic                    coil_rd_o,
  output logic      [15:0]        word_rd_o
);

  logic [(1<<COIL_AW)-1:0] coil_r;
  logic [(1<<COIL_AW)-1:0] coil_nxt;
  logic [15:0]             gp_r  [1<<WORD_AW];
  logic [15:0]             gp_nxt[1<<WORD_AW];
  logic [15:0]             sys_r [1<<WORD_AW];
  logic [15:0]             sys_nxt[1<<WORD_AW];
  logic                    coil_rd_r;
  logic [15:0]             word_rd_r;

  always_comb
  begin
    coil_nxt = coil_r;
    gp_nxt   = gp_r;
    sys_nxt  = sys_r;
    if (wr_i.bit_we)
      coil_nxt[wr_i.addr[COIL_AW-1:0]] = wr_i.bit_val;
    if (wr_i.word_we && wr_i.sys)
      sys_nxt[wr_i.addr[WORD_AW-1:0]] = wr_i.word;
    if (wr_i.word_we && !wr_i.sys)
      gp_nxt[wr_i.addr[WORD_AW-1:0]] = wr_i.word;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      coil_r    <= '0;
      gp_r      <= '{default: 16'h0000};
      sys_r     <= '{default: 16'h0000};
      coil_rd_r <= 1'b0;
      word_rd_r <= 16'h0000;
    end
    else
    begin
      coil_r    <= coil_nxt;
      gp_r      <= gp_nxt;
      sys_r     <= sys_nxt;
      coil_rd_r <= coil_r[coil_rd_addr_i];
      word_rd_r <= word_rd_sys_i ? sys_r[word_rd_addr_i]
                                 : gp_r[word_rd_addr_i];
    end
  end

  assign coil_rd_o = coil_rd_r;
  assign word_rd_o = word_rd_r;

endmodule : mbw_store

`default_nettype wire

// ---- testbench/mb_master_model.sv ----
/*
  Serial bus master model: sends request frames on the receive stream,
  with or without idle gaps, and takes reply bytes promptly or with stalls.
  Assumes the slave's clock and a caller that waits out each reply.
*/
`timescale 1ns/1ps
`default_nettype none

module mb_master_model
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       slow_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_end_o,
  output logic            tx_ready_o
);
  initial
  begin
    rx_byte_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o   = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Reply side stalls at random in slow mode
  always @(posedge clk_i)
  begin
    #1;
    tx_ready_o = arst_n_i && (!slow_i || ($urandom % 3 == 0));
  end

  // Idle cycles alternate between the last byte inverted and the last byte itself
  task automatic send_frame(input logic [7:0] f[$]);
    int i;
    for (i = 0; i < f.size(); i++)
    begin
      if (slow_i)
      begin
        repeat ($urandom % 3)
        begin
          @(posedge clk_i);
          #1;
          rx_valid_o = 1'b0;
          rx_byte_o  = ~rx_byte_o;
        end
      end
      @(posedge clk_i);
      #1;
      rx_byte_o  = f[i];
      rx_valid_o = 1'b1;
      rx_end_o   = (i == f.size() - 1);
    end
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_end_o   = 1'b0;
    rx_byte_o  = ~rx_byte_o;
  endtask : send_frame
endmodule : mb_master_model

`default_nettype wire

// ---- testbench/modbus_write_multiple_slave_test.sv ----
/*
  Self-checking bench of the write-multiple slave: notes of expected
  pulses and reply bytes are queued, a monitor matches them, and shadow
  stores are compared through the read ports.
  Assumes the design package and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module modbus_write_multiple_slave_test
  import mbw_pkg::*;
;
  logic                clk;
  logic                arst_n;
  logic                slow;
  logic [7:0]          own;
  logic [7:0]          rx_byte;
  logic [7:0]          tx_byte;
  logic                rx_valid;
  logic                rx_end;
  logic                tx_valid;
  logic                tx_ready;
  logic                f_ok;
  logic                f_drop;
  logic                coil_rd;
  logic                rd_sys;
  logic [COIL_AW-1:0]  coil_a;
  logic [WORD_AW-1:0]  word_a;
  logic [15:0]         word_rd;
  logic [15:0]         got;
  logic [15:0]         exp;
  logic [15:0]         notes[$];
  logic                coils[2048];
  logic [15:0]         wg[256];
  logic [15:0]         ws[256];
  int                  errors;
  int                  cmp_count;

  always #12.5 clk = ~clk;

  modbus_write_multiple_slave dut (
    .clk_i(clk), .arst_n_i(arst_n), .slave_addr_i(own),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_end_i(rx_end),
    .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .frame_ok_o(f_ok), .frame_drop_o(f_drop),
    .coil_rd_addr_i(coil_a), .word_rd_addr_i(word_a),
    .word_rd_sys_i(rd_sys), .coil_rd_o(coil_rd), .word_rd_o(word_rd));

  mb_master_model mst (
    .clk_i(clk), .arst_n_i(arst_n), .slow_i(slow), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid), .rx_end_o(rx_end), .tx_ready_o(tx_ready));

  // ****************************************************************
  // Monitor and verdict
  // ****************************************************************
  // Sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clk)
  begin
    if (arst_n && (f_ok || f_drop || (tx_valid && tx_ready)))
    begin
      got = f_ok ? 16'h0100 : (f_drop ? 16'h0200 : {8'h00, tx_byte});
      exp = (notes.size() == 0) ? 16'hffff : notes.pop_front();
      `CHK(got, exp)
    end
  end

  task automatic complete_run();
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end

  // ****************************************************************
  // Frame tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc_of

  task automatic frame(input logic [7:0] adr, fn, input logic [15:0] st,
                       n, input logic [7:0] bc, input logic [7:0] d[$],
                       input bit bad, ok);
    logic [7:0]  f[$];
    logic [15:0] c;
    int          k;
    f = {adr, fn, st[15:8], st[7:0], n[15:8], n[7:0]};
    c = crc_of(f);
    notes.push_back(ok ? 16'h0100 : 16'h0200);
    for (k = 0; k < 6 && ok; k++)
      notes.push_back({8'h00, f[k]});
    if (ok)
      notes.push_back({8'h00, c[15:8]});
    if (ok)
      notes.push_back({8'h00, c[7:0]});
    f.push_back(bc);
    f = {f, d};
    c = crc_of(f) ^ {15'h0000, bad};
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    mst.send_frame(f);
    for (k = 0; k < 8000 && notes.size() != 0; k++)
      tick(1);
    if (notes.size() != 0)
    begin
      errors++;
      complete_run();
    end
    tick(4);
  endtask : frame

  task automatic coil_cmd(input logic [7:0] adr, fn, input int st, n, adj,
                          input bit bad, ok);
    logic [7:0] d[$];
    int         j;
    d = {};
    for (j = 0; j < (n + 7) / 8; j++)
      d.push_back(8'($urandom));
    if (n % 8 != 0)
      d[d.size() - 1] &= 8'((1 << (n % 8)) - 1);
    for (j = 0; j < n && ok; j++)
      coils[st + j] = d[j / 8][j % 8];
    frame(adr, fn, 16'(st), 16'(n), 8'(d.size() + adj), d, bad, ok);
    for (j = st; j < st + n && j < 2048; j++)
    begin
      coil_a = 11'(j);
      tick(2);
      `CHK(coil_rd, coils[j])
    end
  endtask : coil_cmd

  task automatic word_cmd(input logic [7:0] adr, fn, input int st, n, adj,
                          input bit bad, ok);
    logic [7:0]  d[$];
    logic [15:0] w;
    int          j;
    d = {};
    for (j = 0; j < n; j++)
    begin
      w = 16'($urandom);
      d.push_back(w[15:8]);
      d.push_back(w[7:0]);
      if (ok && fn == FN_WORDS_SYS)
        ws[st + j] = w;
      else if (ok)
        wg[st + j] = w;
    end
    frame(adr, fn, 16'(st), 16'(n), 8'(2 * n + adj), d, bad, ok);
    for (j = st; j < st + n && j < 256; j++)
    begin
      word_a = 8'(j);
      rd_sys = 1'b0;
      tick(2);
      `CHK(word_rd, wg[j])
      rd_sys = 1'b1;
      tick(2);
      `CHK(word_rd, ws[j])
    end
  endtask : word_cmd

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    slow = 1'b0;
    own = ADDR_MIN;
    coil_a = '0;
    word_a = '0;
    rd_sys = 1'b0;
    errors = 0;
    cmp_count = 0;
    foreach (coils[i]) coils[i] = 1'b0;
    foreach (wg[i]) wg[i] = 16'h0000;
    foreach (ws[i]) ws[i] = 16'h0000;
    void'($urandom(43));
    tick(12);
    arst_n = 1'b1;
    tick(1);
    coil_cmd(ADDR_MIN, FN_COILS, 5, 3, 0, 0, 1);
    own = ADDR_MAX;
    slow = 1'b1;
    coil_cmd(ADDR_MAX, FN_COILS_ALT, 2040, 8, 0, 0, 1);
    coil_cmd(ADDR_MAX, FN_COILS, 0, 1968, 0, 0, 1);
    coil_cmd(ADDR_MAX, FN_COILS, 0, 1969, 0, 0, 0);
    coil_cmd(ADDR_MAX, FN_COILS, 100, 9, 1, 0, 0);
    word_cmd(ADDR_MAX, FN_WORDS, 3, 2, 0, 0, 1);
    slow = 1'b0;
    word_cmd(ADDR_MAX, FN_WORDS_SYS, 3, 2, 0, 0, 1);
    word_cmd(ADDR_MAX, FN_WORDS_SYS, 0, 120, 0, 0, 1);
    word_cmd(ADDR_MAX, FN_WORDS, 0, 121, 0, 0, 0);
    word_cmd(ADDR_MAX, FN_WORDS, 7, 4, -1, 0, 0);
    word_cmd(ADDR_MAX, FN_WORDS, 7, 4, 0, 1, 0);
    word_cmd(8'h33, FN_WORDS, 7, 4, 0, 0, 0);
    word_cmd(ADDR_MAX, 8'h06, 7, 4, 0, 0, 0);
    own = 8'hf8;
    coil_cmd(8'hf8, FN_COILS, 0, 8, 0, 0, 0);
    complete_run();
  end
endmodule : modbus_write_multiple_slave_test

`default_nettype wire
